// ===== wsc_pkg.sv
// Constants, register map and carrier types of the weighing cut-off controller.
// Assumes a 20 MHz system clock and an APB register port with 32-bit data.
package wsc_pkg;
    localparam int WW = 20;
    typedef logic signed [WW-1:0] wsc_wt_t;

    // Control word: tare limits, view selection, key locks, direction, sources
    typedef struct packed {
        logic       cmpGross;
        logic       nzGross;
        logic       digitalTareOn;
        logic [1:0] dirMode;
        logic [3:0] keyOff;
        logic       netInvert;
        logic       extGnLevel;
        logic       tareExp;
        logic       tareView;
        logic       tareRestrict;
        logic       tareStable;
    } wsc_ctrl_t;
    localparam int CTRL_W = $bits(wsc_ctrl_t);
    localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;

    typedef struct packed {
        logic finalCutoffOutput;
        logic secondCutoffOutput;
        logic firstCutoffOutput;
    } wsc_cut_t;

    typedef struct packed {
        logic over;
        logic under;
        logic go;
    } wsc_judge_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMP  = 5'h02,
        ST_INH  = 5'h04,
        ST_JDG  = 5'h08,
        ST_DONE = 5'h10
    } wsc_state_t;

    // Register index; byte address is four times the index
    localparam logic [3:0] IX_CTRL   = 4'h0;
    localparam logic [3:0] IX_FINAL  = 4'h1;
    localparam logic [3:0] IX_SP1    = 4'h2;
    localparam logic [3:0] IX_SP2    = 4'h3;
    localparam logic [3:0] IX_COMP   = 4'h4;
    localparam logic [3:0] IX_OVER   = 4'h5;
    localparam logic [3:0] IX_UNDER  = 4'h6;
    localparam logic [3:0] IX_NZ     = 4'h7;
    localparam logic [3:0] IX_LOWL   = 4'h8;
    localparam logic [3:0] IX_UPL    = 4'h9;
    localparam logic [3:0] IX_CAP    = 4'ha;
    localparam logic [3:0] IX_TAREWT = 4'hb;
    localparam logic [3:0] IX_INH    = 4'hc;
    localparam logic [3:0] IX_JDG    = 4'hd;
    localparam logic [3:0] IX_STAT   = 4'he;
    localparam logic [3:0] IX_CYCLE  = 4'hf;
    localparam wsc_wt_t    PAR_RST   = 20'h00000;

    localparam logic [1:0] DIR_FEED  = 2'h0;
    localparam logic [1:0] DIR_DISCH = 2'h1;
    localparam logic [1:0] DIR_EXT   = 2'h2;

    // Synchronised pin vector positions; the first four are lockable keys
    localparam int K_TARE = 0;
    localparam int K_TRST = 1;
    localparam int K_ZERO = 2;
    localparam int K_GN   = 3;
    localparam int K_VIEW = 4;
    localparam int P_TON  = 5;
    localparam int P_TOFF = 6;
    localparam int P_VIEW = 7;
    localparam int P_DIR  = 8;
    localparam int PIN_N  = 9;

    // Timer tick of the inhibit and judging timers
    localparam int CLK_NS           = 50;
    localparam int TICK_US          = 1000;
    localparam int TICK_CYCLES_DFLT = TICK_US * 1000 / CLK_NS;
    localparam logic [15:0] TMR_ONE = 16'h0001;
endpackage

// ===== wsc_top.sv
// Cut-off, judgment, limit, tare and view control of a weighing instrument.
// Assumes grossWeight and weightStable come from logic on clk; keys and
// connector inputs are asynchronous pins. Valves are driven by an outside sequencer.
// Notes on behaviour
// - Tare accepted always, or only while weight is stable, by setting.
// - Restricted tare range accepts only 0 < tare <= capacity.
// - With tare view enabled, view key shows stored tare on display.
// - With expansion on, tare value and digital tare switch locked while tare active.
// - Internal key mode: gross/net from front key or input edges.
// - Internal key mode: rising input edge selects net, falling selects gross.
// - External input mode: input level high shows net, low shows gross.
// - External switchover mode ignores the front gross/net key.
// - Setting inverts net weight sign so discharged material reads positive.
// - Tare, tare reset, zero and gross/net keys individually lockable.
// - Tare input or key captures current weight as tare, zeroing net.
// - First cut-off asserts when weight reaches final minus first amount.
// - Second cut-off asserts when weight reaches final minus second amount.
// - First or second cut-off starts nonzero inhibit timer suppressing comparison.
// - Final cut-off at final minus compensation; starts judging timer if set.
// - Judging timer expiry makes over/under judgment outside tolerance band.
// - Near-zero output tells the vessel is empty for the next cycle.
// - Discharging treats discharged quantity as negative weight, same comparisons.
// - Lower-limit when vessel short, upper-limit when full; sequencer feeds between.
// - Direction fixed feeding, fixed discharging, or chosen by external input.
// - External direction input low selects feeding, high selects discharging.
// - Over above final+over, under at or below final-under, otherwise go.
// - Near-zero whenever selected weight is at or below near-zero setting.
`timescale 1ns/1ns
module wsc_top
    import wsc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input  logic        clk,
    input  logic        reset_n,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  wsc_wt_t     grossWeight,
    input  logic        weightStable,
    input  logic [4:0]  frontKeys,
    input  logic        extTareOn,
    input  logic        extTareOff,
    input  logic        weightViewSelectInput,
    input  logic        feedDischargeInput,
    output wsc_cut_t    cutoffs,
    output wsc_judge_t  judgment,
    output logic        nearZero,
    output logic        lowerLimit,
    output logic        upperLimit,
    output logic        showNet,
    output logic        showTare,
    output wsc_wt_t     displayWeight,
    output logic        zeroRequest
);
    function automatic wsc_wt_t pick(input logic useGross, input wsc_wt_t g, input wsc_wt_t n);
        pick = useGross ? g : n;
    endfunction

    logic [PIN_N-1:0] pinRaw;
    logic [PIN_N-1:0] pinMeta_r;
    logic [PIN_N-1:0] pinSync_r;
    logic [PIN_N-1:0] pinPrev_r;
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;
    wsc_ctrl_t        ctrl_r;
    wsc_wt_t          par_r [IX_FINAL:IX_JDG];
    logic [31:0]      prdata_r;
    logic [3:0]       idx;
    logic             mapped;
    logic             apbWr;
    logic             tareLock;
    logic             cycleWrite;
    logic [3:0]       keyHit;
    logic             tareReq;
    logic             tareAccept;
    logic             tareRst;
    logic             tareActive_r;
    wsc_wt_t          tareVal_r;
    wsc_wt_t          tareTotal;
    wsc_wt_t          netRaw;
    wsc_wt_t          netWeight;
    logic             showNet_r;
    logic             showTare_r;
    wsc_wt_t          display_r;
    logic             zero_r;
    logic             discharging;
    wsc_wt_t          cmpW;
    wsc_wt_t          nzW;
    logic [2:0]       hits;
    logic             newSp12;
    logic             newCycle;
    logic             judgeNow;
    logic [15:0]      divCnt_r;
    logic             tick;
    logic [15:0]      timer_r;
    logic             expire;
    wsc_state_t       state_r;
    wsc_cut_t         cut_r;
    wsc_judge_t       judge_r;
    logic             nearZero_r;
    logic             lower_r;
    logic             upper_r;

    assign pinRaw = {feedDischargeInput, weightViewSelectInput, extTareOff, extTareOn, frontKeys};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
            pinPrev_r <= '0;
        end else begin
            pinMeta_r <= pinRaw;
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end
    assign rise = pinSync_r & ~pinPrev_r;
    assign fall = ~pinSync_r & pinPrev_r;

    // APB slave: zero wait states, read data latched in the setup cycle
    assign idx        = paddr[5:2];
    assign mapped     = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
    assign apbWr      = psel && penable && pwrite && mapped;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped;
    assign prdata     = prdata_r;
    assign tareLock   = ctrl_r.tareExp && tareActive_r;
    assign cycleWrite = apbWr && (idx == IX_CYCLE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RST;
            for (int i = IX_FINAL; i <= IX_JDG; i++) begin
                par_r[i] <= PAR_RST;
            end
        end else if (apbWr) begin
            if (idx == IX_CTRL) begin
                ctrl_r <= wsc_ctrl_t'(pwdata[CTRL_W-1:0]);
                if (tareLock) begin
                    ctrl_r.digitalTareOn <= ctrl_r.digitalTareOn;
                end
            end else if (idx >= IX_FINAL && idx <= IX_JDG) begin
                if (!(idx == IX_TAREWT && tareLock)) begin
                    par_r[idx] <= pwdata[WW-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_r <= '0;
        end else if (psel && !penable) begin
            prdata_r <= '0;
            if (!mapped) begin
                prdata_r <= '0;
            end else if (idx == IX_CTRL) begin
                prdata_r[CTRL_W-1:0] <= ctrl_r;
            end else if (idx >= IX_FINAL && idx <= IX_JDG) begin
                prdata_r <= {{(32-WW){par_r[idx][WW-1]}}, par_r[idx]};
            end else if (idx == IX_STAT) begin
                prdata_r[16:0] <= {state_r, judge_r, cut_r, nearZero_r, lower_r, upper_r,
                                   tareActive_r, showNet_r, showTare_r};
            end
        end
    end

    // Tare capture and reset
    assign keyHit  = rise[K_GN:K_TARE] & ~ctrl_r.keyOff;
    assign tareReq = keyHit[K_TARE] || rise[P_TON];
    assign tareRst = keyHit[K_TRST] || rise[P_TOFF];
    assign tareAccept = tareReq
        && (!ctrl_r.tareStable || weightStable)
        && (!ctrl_r.tareRestrict || (grossWeight > PAR_RST && grossWeight <= par_r[IX_CAP]));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tareActive_r <= 1'b0;
            tareVal_r    <= PAR_RST;
        end else if (tareAccept) begin
            tareActive_r <= 1'b1;
            tareVal_r    <= grossWeight;
        end else if (tareRst) begin
            tareActive_r <= 1'b0;
        end
    end

    assign tareTotal = tareActive_r ? tareVal_r
                     : (ctrl_r.digitalTareOn ? par_r[IX_TAREWT] : PAR_RST);
    assign netRaw    = grossWeight - tareTotal;
    assign netWeight = ctrl_r.netInvert ? -netRaw : netRaw;

    // Gross/net view selection and tare view
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            showNet_r <= 1'b0;
        end else if (ctrl_r.extGnLevel) begin
            showNet_r <= pinSync_r[P_VIEW];
        end else if (rise[P_VIEW]) begin
            showNet_r <= 1'b1;
        end else if (fall[P_VIEW]) begin
            showNet_r <= 1'b0;
        end else if (keyHit[K_GN]) begin
            showNet_r <= !showNet_r;
        end
    end

    // Tare view ends when the gross/net view is changed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            showTare_r <= 1'b0;
        end else if (!ctrl_r.tareView) begin
            showTare_r <= 1'b0;
        end else if (rise[K_VIEW]) begin
            showTare_r <= !showTare_r;
        end else if (showNet_r != $past(showNet_r)) begin
            showTare_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            display_r <= PAR_RST;
            zero_r    <= 1'b0;
        end else begin
            display_r <= showTare_r ? tareTotal : pick(!showNet_r, grossWeight, netWeight);
            zero_r    <= keyHit[K_ZERO];
        end
    end

    // Comparison value, direction and thresholds
    assign discharging = (ctrl_r.dirMode == DIR_DISCH)
                      || (ctrl_r.dirMode == DIR_EXT && pinSync_r[P_DIR]);
    assign cmpW = discharging ? -pick(ctrl_r.cmpGross, grossWeight, netWeight)
                              : pick(ctrl_r.cmpGross, grossWeight, netWeight);
    assign nzW  = pick(ctrl_r.nzGross, grossWeight, netWeight);
    assign hits[0] = cmpW >= par_r[IX_FINAL] - par_r[IX_SP1];
    assign hits[1] = cmpW >= par_r[IX_FINAL] - par_r[IX_SP2];
    assign hits[2] = cmpW >= par_r[IX_FINAL] - par_r[IX_COMP];
    assign newSp12 = (hits[0] && !cut_r.firstCutoffOutput) || (hits[1] && !cut_r.secondCutoffOutput);
    assign newCycle = tareAccept || cycleWrite;

    // Millisecond tick for the inhibit and judging timers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_r <= '0;
        end else if (divCnt_r >= 16'(TICK_CYCLES - 1)) begin
            divCnt_r <= '0;
        end else begin
            divCnt_r <= divCnt_r + TMR_ONE;
        end
    end
    assign tick   = divCnt_r >= 16'(TICK_CYCLES - 1);
    assign expire = tick && timer_r <= TMR_ONE;
    assign judgeNow = (state_r == ST_CMP && hits[2] && par_r[IX_JDG][15:0] == 16'h0000)
                   || (state_r == ST_JDG && expire);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cut_r   <= '0;
            timer_r <= '0;
        end else if (newCycle) begin
            state_r <= ST_CMP;
            cut_r   <= '0;
            timer_r <= '0;
        end else begin
            case (state_r)
                ST_CMP: begin
                    cut_r <= cut_r | hits;
                    if (hits[2]) begin
                        if (par_r[IX_JDG][15:0] != 16'h0000) begin
                            state_r <= ST_JDG;
                            timer_r <= par_r[IX_JDG][15:0];
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end else if (newSp12 && par_r[IX_INH][15:0] != 16'h0000) begin
                        state_r <= ST_INH;
                        timer_r <= par_r[IX_INH][15:0];
                    end
                end
                ST_INH, ST_JDG: begin
                    if (expire) begin
                        state_r <= (state_r == ST_INH) ? ST_CMP : ST_DONE;
                    end else if (tick) begin
                        timer_r <= timer_r - TMR_ONE;
                    end
                end
                ST_IDLE, ST_DONE: begin
                    state_r <= state_r;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            judge_r <= '0;
        end else if (newCycle) begin
            judge_r <= '0;
        end else if (judgeNow) begin
            judge_r.over  <= cmpW > par_r[IX_FINAL] + par_r[IX_OVER];
            judge_r.under <= cmpW <= par_r[IX_FINAL] - par_r[IX_UNDER];
            judge_r.go    <= cmpW <= par_r[IX_FINAL] + par_r[IX_OVER]
                          && cmpW > par_r[IX_FINAL] - par_r[IX_UNDER];
        end
    end

    // Level outputs; the sequencer opens and closes valves from these
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nearZero_r <= 1'b0;
            lower_r    <= 1'b0;
            upper_r    <= 1'b0;
        end else begin
            nearZero_r <= nzW <= par_r[IX_NZ];
            lower_r    <= grossWeight <= par_r[IX_LOWL];
            upper_r    <= grossWeight >= par_r[IX_UPL];
        end
    end

    assign cutoffs       = cut_r;
    assign judgment      = judge_r;
    assign nearZero      = nearZero_r;
    assign lowerLimit    = lower_r;
    assign upperLimit    = upper_r;
    assign showNet       = showNet_r;
    assign showTare      = showTare_r;
    assign displayWeight = display_r;
    assign zeroRequest   = zero_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_tare_stable: assert property (tareAccept && ctrl_r.tareStable |-> weightStable)
        else $error("tare taken while weight unstable");
    chk_tare_range: assert property (tareAccept && ctrl_r.tareRestrict |=>
            tareVal_r > PAR_RST && tareVal_r <= $past(par_r[IX_CAP]))
        else $error("tare outside permitted range");
    chk_tare_lock: assert property (apbWr && idx == IX_TAREWT && tareLock |=>
            $stable(par_r[IX_TAREWT]))
        else $error("tare weight changed while locked");
    chk_level_view: assert property (ctrl_r.extGnLevel && $stable(ctrl_r) |=>
            showNet_r == $past(pinSync_r[P_VIEW]))
        else $error("view does not follow input level");
    chk_edge_net: assert property (!ctrl_r.extGnLevel && rise[P_VIEW] |=> showNet_r)
        else $error("rising edge did not select net");
    chk_first_cut: assert property (state_r == ST_CMP && !newCycle && hits[0] |=>
            cut_r.firstCutoffOutput)
        else $error("first cut-off missed");
    chk_inhibit_start: assert property (state_r == ST_CMP && !newCycle && !hits[2] && newSp12
            && par_r[IX_INH][15:0] != 16'h0000 |=> state_r == ST_INH
            && timer_r == $past(par_r[IX_INH][15:0]))
        else $error("inhibit timer not started");
    chk_judge_over: assert property (judgeNow && !newCycle
            && cmpW > par_r[IX_FINAL] + par_r[IX_OVER] |=> judge_r.over && !judge_r.go)
        else $error("over judgment wrong");
    chk_near_zero: assert property (nzW <= par_r[IX_NZ] |=> nearZero_r)
        else $error("near-zero not asserted");
    chk_judge_hold: assert property (!newCycle && !judgeNow |=> $stable(judge_r))
        else $error("judgment changed without cause");

    cov_full_cycle: cover property (state_r == ST_JDG ##[1:1000] state_r == ST_DONE);
    cov_inhibit: cover property (state_r == ST_INH ##1 state_r == ST_CMP);
    cov_under: cover property (judge_r.under);
    cov_locked_write: cover property (apbWr && idx == IX_TAREWT && tareLock);
endmodule

// ===== wsc_seq_model.sv
// Behavioural outside sequencer with a hopper that fills while its feed valve is open and final cut-off is off.
// Assumes the bench may load a weight directly; a load also shuts the feed valve.
`timescale 1ns/1ns
module wsc_seq_model
    import wsc_pkg::*;
(
    input  logic     clk,
    input  logic     loadEn,
    input  wsc_wt_t  loadWt,
    input  wsc_cut_t cutoffs,
    input  logic     lowerLimit,
    input  logic     upperLimit,
    output logic     feedOpen,
    output wsc_wt_t  grossWeight
);
    initial begin
        feedOpen = 1'b0;
        grossWeight = '0;
    end

    // Valve logic lives here, never in the controller
    always @(posedge clk) begin
        if (loadEn) begin
            feedOpen <= 1'b0;
        end else if (lowerLimit) begin
            feedOpen <= 1'b1;
        end else if (upperLimit) begin
            feedOpen <= 1'b0;
        end
        if (loadEn) begin
            grossWeight <= loadWt;
        end else if (feedOpen && !cutoffs.finalCutoffOutput) begin
            grossWeight <= grossWeight + 20'sh00005;
        end
    end
endmodule

// ===== wsc_tb.sv
// Self-checking bench for the weighing cut-off controller.
// Assumes wsc_top with a 4-clock timer tick and the sequencer model beside it.
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench import wsc_pkg::*;;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, errv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        weightStable, extTareOn, extTareOff, weightViewSelectInput, feedDischargeInput;
    logic [4:0]  frontKeys;
    logic        loadEn, feedOpen, nearZero, lowerLimit, upperLimit, showNet, showTare, zeroRequest;
    wsc_wt_t     loadWt, grossWeight, displayWeight;
    wsc_cut_t    cutoffs;
    wsc_judge_t  judgment;
    wsc_ctrl_t   ctrl;
    int          err_count, num_checks, zeroCnt, i;
    int          rv[3] = '{0, 1200, 1000};
    int          rx[3] = '{-300, 900, 0};
    int          cw[6] = '{699, 700, 899, 900, 979, 980};
    logic [2:0]  ce[6] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h3, 3'h7};
    int          jw[4] = '{1011, 1010, 990, 991};
    logic [2:0]  je[4] = '{3'h4, 3'h1, 3'h2, 3'h1};

    wsc_top #(.TICK_CYCLES(4)) wsc_top_inst (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .grossWeight, .weightStable, .frontKeys, .extTareOn, .extTareOff,
        .weightViewSelectInput, .feedDischargeInput, .cutoffs, .judgment, .nearZero, .lowerLimit,
        .upperLimit, .showNet, .showTare, .displayWeight, .zeroRequest);
    wsc_seq_model wsc_seq_model_inst (.clk, .loadEn, .loadWt, .cutoffs, .lowerLimit, .upperLimit,
        .feedOpen, .grossWeight);

    function automatic wsc_wt_t wt(input int v);
        return wsc_wt_t'(v);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] ix, input logic [31:0] d);
        apb(1'b1, {2'h0, ix, 2'h0}, d);
    endtask
    task automatic rd(input logic [3:0] ix);
        apb(1'b0, {2'h0, ix, 2'h0}, 32'h0);
    endtask
    task automatic setc;
        wr(IX_CTRL, 32'(ctrl));
        tick(2);
    endtask
    // Empty the hopper first so a weight left from the last scenario cannot hit the fresh cycle
    task automatic cyc;
        ld(0);
        wr(IX_CYCLE, 32'h0);
    endtask
    task automatic ld(input int v);
        loadEn <= 1'b1;
        loadWt <= wt(v);
        tick(1);
        loadEn <= 1'b0;
        tick(4);
    endtask
    // Pins pass a two-stage synchroniser, so each level is held five clocks
    task automatic key(input int k);
        frontKeys[k] <= 1'b1;
        tick(5);
        frontKeys[k] <= 1'b0;
        tick(5);
    endtask
    task automatic tare(input logic off);
        if (off) extTareOff <= 1'b1;
        else extTareOn <= 1'b1;
        tick(5);
        extTareOff <= 1'b0;
        extTareOn <= 1'b0;
        tick(5);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (zeroRequest === 1'b1) zeroCnt++;
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop;
    end

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, weightStable, extTareOn, extTareOff} = '0;
        {weightViewSelectInput, feedDischargeInput, frontKeys, loadEn, loadWt, ctrl} = '0;
        {err_count, num_checks, zeroCnt} = '0;
        tick(12);
        reset_n <= 1'b1;
        tick(1);
        rd(IX_FINAL);
        `CHK(rdv, 32'h0)
        wr(IX_LOWL, 32'(wt(-99999)));
        wr(IX_UPL, 32'h1869f);
        rd(IX_LOWL);
        `CHK(rdv, 32'(wt(-99999)))
        apb(1'b0, 8'h40, 32'h0);
        `CHK({errv, rdv}, 33'h100000000)
        weightStable <= 1'b1;
        ld(200);
        weightViewSelectInput <= 1'b1;
        tick(5);
        `CHK(showNet, 1'b1)
        tare(1'b0);
        `CHK(displayWeight, wt(0))
        ld(250);
        `CHK(displayWeight, wt(50))
        ctrl.netInvert = 1'b1;
        setc;
        `CHK(displayWeight, wt(-50))
        ctrl.netInvert = 1'b0;
        setc;
        weightViewSelectInput <= 1'b0;
        tick(5);
        `CHK({showNet, displayWeight}, {1'b0, wt(250)})
        ctrl.keyOff[K_GN] = 1'b1;
        setc;
        key(K_GN);
        `CHK(showNet, 1'b0)
        ctrl.keyOff[K_GN] = 1'b0;
        setc;
        key(K_GN);
        `CHK(showNet, 1'b1)
        key(K_ZERO);
        ctrl.keyOff[K_ZERO] = 1'b1;
        setc;
        key(K_ZERO);
        `CHK(zeroCnt, 1)
        ctrl.keyOff = 4'h0;
        ctrl.extGnLevel = 1'b1;
        setc;
        weightViewSelectInput <= 1'b1;
        tick(5);
        key(K_GN);
        `CHK(showNet, 1'b1)
        weightViewSelectInput <= 1'b0;
        tick(5);
        `CHK(showNet, 1'b0)
        ctrl.extGnLevel = 1'b0;
        ctrl.tareView = 1'b1;
        setc;
        weightViewSelectInput <= 1'b1;
        tick(5);
        key(K_VIEW);
        `CHK({showTare, displayWeight}, {1'b1, wt(200)})
        key(K_VIEW);
        ctrl.tareView = 1'b0;
        setc;
        key(K_VIEW);
        `CHK(showTare, 1'b0)
        ctrl.tareStable = 1'b1;
        setc;
        weightStable <= 1'b0;
        ld(300);
        tare(1'b0);
        `CHK(displayWeight, wt(100))
        weightStable <= 1'b1;
        tare(1'b0);
        `CHK(displayWeight, wt(0))
        ctrl.tareRestrict = 1'b1;
        setc;
        wr(IX_CAP, 32'h3e8);
        for (i = 0; i < 3; i++) begin
            ld(rv[i]);
            tare(1'b0);
            `CHK(displayWeight, wt(rx[i]))
        end
        ctrl.tareExp = 1'b1;
        setc;
        wr(IX_TAREWT, 32'h4d);
        rd(IX_TAREWT);
        `CHK(rdv, 32'h0)
        tare(1'b1);
        wr(IX_TAREWT, 32'h4d);
        rd(IX_TAREWT);
        `CHK(rdv, 32'h4d)
        ctrl = '0;
        ctrl.cmpGross = 1'b1;
        setc;
        wr(IX_FINAL, 32'h3e8);
        wr(IX_SP1, 32'h12c);
        wr(IX_SP2, 32'h64);
        wr(IX_COMP, 32'h14);
        wr(IX_OVER, 32'ha);
        wr(IX_UNDER, 32'ha);
        wr(IX_JDG, 32'h1);
        cyc;
        for (i = 0; i < 6; i++) begin
            ld(cw[i]);
            `CHK(cutoffs, ce[i])
        end
        tick(12);
        `CHK(judgment, 3'h2)
        ld(1005);
        tick(12);
        `CHK(judgment, 3'h2)
        for (i = 0; i < 4; i++) begin
            cyc;
            `CHK({cutoffs, judgment}, 6'h0)
            ld(jw[i]);
            tick(12);
            `CHK(judgment, je[i])
        end
        wr(IX_INH, 32'h5);
        cyc;
        ld(700);
        ld(1000);
        `CHK(cutoffs, 3'h1)
        tick(30);
        `CHK(cutoffs, 3'h7)
        wr(IX_INH, 32'h0);
        ctrl.dirMode = DIR_DISCH;
        setc;
        cyc;
        ld(-700);
        `CHK(cutoffs, 3'h1)
        ld(-980);
        `CHK(cutoffs, 3'h7)
        ctrl.dirMode = DIR_EXT;
        setc;
        feedDischargeInput <= 1'b1;
        tick(5);
        cyc;
        ld(-700);
        `CHK(cutoffs, 3'h1)
        feedDischargeInput <= 1'b0;
        tick(5);
        cyc;
        ld(-700);
        `CHK(cutoffs, 3'h0)
        ld(700);
        `CHK(cutoffs, 3'h1)
        ctrl.nzGross = 1'b1;
        ctrl.dirMode = DIR_FEED;
        setc;
        wr(IX_NZ, 32'h32);
        ld(50);
        `CHK(nearZero, 1'b1)
        ld(51);
        `CHK(nearZero, 1'b0)
        wr(IX_FINAL, 32'hc350);
        wr(IX_LOWL, 32'h64);
        wr(IX_UPL, 32'h190);
        cyc;
        ld(0);
        `CHK({lowerLimit, feedOpen}, 2'h3)
        for (i = 0; i < 400 && feedOpen !== 1'b0; i++) tick(1);
        `CHK(upperLimit, 1'b1)
        `CHK(grossWeight >= wt(400) && grossWeight <= wt(430), 1'b1)
        report_and_stop;
    end
endmodule
